/* hdl/fotc_pkg.sv */
/*
 Shared constants and types of the flow output and totaliser block.
 Assumes a 200 MHz system clock; long counts are scaled from it.
*/
`default_nettype none
package fotc_pkg;
   localparam int unsigned     VALUE_W         = 16;
   localparam int unsigned     TOTAL_W         = 32;
   localparam int unsigned     CLOCK_HZ        = 200_000_000;
   localparam int unsigned     HOUR_S          = 3600;
   localparam longint unsigned HOUR_CYCLES_DEF = longint'(HOUR_S) * longint'(CLOCK_HZ);
   localparam int unsigned     PULSE_CYCLES_DEF = 1000;
   localparam logic [10:0]     HOURS_PER_DAY   = 11'h018;
   localparam logic [10:0]     HOURS_PER_WEEK  = 11'h0A8;
   localparam logic [2:0]      DAMP_MAX_SHIFT  = 3'h5;
   localparam logic [15:0]     CUR_MIN_UA      = 16'h0FA0;
   localparam logic [15:0]     CUR_MAX_UA      = 16'h4E20;
   localparam logic [31:0]     CUR_SPAN_UA     = 32'h0000_3E80;
   localparam logic [15:0]     CUR_NONE_UA     = 16'h0000;
   localparam logic [1:0]      SPAN_SHIFT      = 2'h2;

   typedef enum logic [2:0] {
      FN_HYST_NO = 3'h0,
      FN_HYST_NC = 3'h1,
      FN_WIN_NO  = 3'h2,
      FN_WIN_NC  = 3'h3,
      FN_PULSE   = 3'h4,
      FN_ANALOG  = 3'h5,
      FN_RSTIN   = 3'h6
   } fotc_func_type;

   typedef enum logic [1:0] {
      TRIG_RISE = 2'h0,
      TRIG_FALL = 2'h1,
      TRIG_HIGH = 2'h2,
      TRIG_LOW  = 2'h3
   } fotc_trig_type;

   typedef enum logic [1:0] {
      ERR_NORMAL = 2'h0,
      ERR_ON     = 2'h1,
      ERR_OFF    = 2'h2
   } fotc_err_type;

   typedef enum logic [1:0] {
      UNIT_OFF  = 2'h0,
      UNIT_HOUR = 2'h1,
      UNIT_DAY  = 2'h2,
      UNIT_WEEK = 2'h3
   } fotc_unit_type;

   typedef enum logic {
      MENU_MAIN = 1'h0,
      MENU_EXT  = 1'h1
   } fotc_menu_type;
endpackage : fotc_pkg
`default_nettype wire

/* hdl/fotc_sw_if.sv */
/*
 Carrier between the top and one switching comparator.
 Assumes the top drives thresholds and mode, the comparator the level.
*/
`timescale 1ns/1ps
`default_nettype none
interface fotc_sw_if #(parameter int unsigned W = 16);
   logic [W-1:0] value;
   logic [W-1:0] upper;
   logic [W-1:0] lower;
   logic         window;
   logic         closed;
   logic         level;
   modport ctrl (output value, output upper, output lower, output window, output closed, input level);
   modport sw   (input value, input upper, input lower, input window, input closed, output level);
endinterface : fotc_sw_if
`default_nettype wire

/* hdl/fotc_switch.sv */
/*
 Hysteresis and window comparator for one switching output.
 Assumes lower stays below upper; the top refuses other settings.
*/
`timescale 1ns/1ps
`default_nettype none
module fotc_switch (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Thresholds in, level out
   fotc_sw_if.sw    port
);
   logic hyst_q;
   logic hyst_d;
   logic aboveUpper;
   logic belowLower;
   logic inWindow;
   logic openLevel;

   assign aboveUpper = port.value > port.upper;
   assign belowLower = port.value < port.lower;
   // Between the points the hysteresis state holds
   assign hyst_d     = aboveUpper ? 1'b1 : (belowLower ? 1'b0 : hyst_q);
   assign inWindow   = !aboveUpper && !belowLower;
   assign openLevel  = port.window ? inWindow : hyst_q;
   assign port.level = openLevel ^ port.closed;

   always_ff @(posedge clock) begin
      if (!rst_n) hyst_q <= 1'b0;
      else hyst_q <= hyst_d;
   end

   a_hyst_upper: assert property (@(posedge clock) disable iff (!rst_n) aboveUpper |=> hyst_q)
      else $error("hysteresis did not set above upper point");
   a_hyst_lower: assert property (@(posedge clock) disable iff (!rst_n) belowLower |=> !hyst_q)
      else $error("hysteresis did not clear below lower point");
   a_window_sense: assert property (@(posedge clock) disable iff (!rst_n)
      port.window |-> (port.level == ((port.value >= port.lower && port.value <= port.upper) ^ port.closed)))
      else $error("window level wrong");
   c_window_hit: cover property (@(posedge clock) disable iff (!rst_n) port.window && inWindow);
endmodule : fotc_switch
`default_nettype wire

/* hdl/fotc_top.sv */
/*
 Output, totaliser and configuration logic of a flow probe.
 Assumes every input synchronous to clock; buttons arrive as one-cycle requests.
*/
// Contract
// - Output one: four switching modes plus pulse
// - Output two: switching, 4-20 mA, reset input
// - Start value maps to 4 mA
// - End value maps to 20 mA
// - Refuse start/end closer than quarter range
// - Reset trigger selectable, only in input mode
// - On trigger save total, then clear it
// - Track highest and lowest flow since clear
// - Min/max memory clears on button request
// - Error behaviour on forces output on
// - Error behaviour off forces off; counter stops
// - Normal behaviour ignores internal error
// - Timed interval clears counter, restarts interval
// - Without interval, 32-bit counter wraps only
// - Manual clear zeroes counter, new interval
// - Manual clear works with timed interval set
// - Extended entry opens submenu on set press
// - Diameter changeable only in submenu, lockable
// - Pulse repeat emits pulse, else latches on
// - Switch above upper, return below lower point
`timescale 1ns/1ps
`default_nettype none
module fotc_top #(
   parameter int unsigned     VALUE_W      = fotc_pkg::VALUE_W,
   parameter logic [15:0]     RANGE_FINAL  = 16'hFFFF,
   parameter logic [15:0]     DIAMETER_RST = 16'h0032,
   parameter longint unsigned HOUR_CYCLES  = fotc_pkg::HOUR_CYCLES_DEF,
   parameter int unsigned     PULSE_CYCLES = fotc_pkg::PULSE_CYCLES_DEF
) (
   // Clock and reset
   input  wire logic                   clock,
   input  wire logic                   rst_n,
   // Measurement and events
   input  wire logic [VALUE_W-1:0]     flowValue,
   input  wire logic                   flowValid,
   input  wire logic                   quantityTick,
   input  wire logic                   internalError,
   // Output functions and error behaviour
   input  wire fotc_pkg::fotc_func_type firstOutputFunction,
   input  wire fotc_pkg::fotc_func_type secondOutputFunction,
   input  wire fotc_pkg::fotc_err_type  errorBehaviour1,
   input  wire fotc_pkg::fotc_err_type  errorBehaviour2,
   // Switch point writes
   input  wire logic                   switchWrite1,
   input  wire logic                   switchWrite2,
   input  wire logic [VALUE_W-1:0]     upperSwitchPoint,
   input  wire logic [VALUE_W-1:0]     lowerReturnPoint,
   // Analogue scaling write
   input  wire logic                   analogueWrite,
   input  wire logic [VALUE_W-1:0]     analogueStartValue,
   input  wire logic [VALUE_W-1:0]     analogueEndValue,
   // Counter and pulse settings
   input  wire fotc_pkg::fotc_trig_type resetTrigger,
   input  wire fotc_pkg::fotc_unit_type intervalUnit,
   input  wire logic [4:0]             intervalCount,
   input  wire logic                   pulseRepeatEnable,
   input  wire logic [31:0]            pulseQuantityValue,
   input  wire logic [2:0]             dampingConstant,
   // Button requests
   input  wire logic                   manualCounterClear,
   input  wire logic                   minMaxClear,
   input  wire logic                   flashAck,
   input  wire logic                   extendedMenu,
   input  wire logic                   menuExit,
   input  wire logic                   diameterWrite,
   input  wire logic [15:0]            diameterValue,
   input  wire logic                   factoryLock,
   // Output pins
   output logic                        out1Level,
   output logic                        out2Out,
   output logic                        out2Oe,
   input  wire logic                   out2In,
   output logic [15:0]                 analogueCurrent,
   // Status
   output logic [31:0]                 totaliser,
   output logic [31:0]                 savedTotal,
   output logic                        savedFlash,
   output logic [VALUE_W-1:0]          maxFlowMemory,
   output logic [VALUE_W-1:0]          minFlowMemory,
   output logic                        flowMemoryValid,
   output logic [VALUE_W-1:0]          dampedFlow,
   output logic                        inSubmenu,
   output logic [15:0]                 pipeInnerDiameter,
   output logic                        switchRefused,
   output logic                        analogueRefused,
   output logic                        diameterRefused
);
   localparam int unsigned PRE_W  = $clog2(HOUR_CYCLES + 1);
   localparam int unsigned PLS_W  = $clog2(PULSE_CYCLES + 1);
   localparam logic [PRE_W-1:0] HOUR_LAST = PRE_W'(HOUR_CYCLES - 1);
   localparam logic [VALUE_W-1:0] SPAN_MIN = VALUE_W'(RANGE_FINAL >> fotc_pkg::SPAN_SHIFT);

   function automatic logic applyErr(input logic lvl, input fotc_pkg::fotc_err_type beh, input logic err);
      if (err && beh == fotc_pkg::ERR_ON) applyErr = 1'b1;
      else if (err && beh == fotc_pkg::ERR_OFF) applyErr = 1'b0;
      else applyErr = lvl;
   endfunction : applyErr

   function automatic logic isSwitch(input fotc_pkg::fotc_func_type fn);
      isSwitch = fn inside {fotc_pkg::FN_HYST_NO, fotc_pkg::FN_HYST_NC, fotc_pkg::FN_WIN_NO, fotc_pkg::FN_WIN_NC};
   endfunction : isSwitch

   // Counts beyond 23 h, 6 d or 8 w are not refused; the product is cut to eleven bits
   function automatic logic [10:0] intervalHours(input fotc_pkg::fotc_unit_type u, input logic [4:0] n);
      logic [10:0] cnt;
      cnt = {6'h00, n};
      unique case (u)
         fotc_pkg::UNIT_OFF:  intervalHours = 11'h000;
         fotc_pkg::UNIT_HOUR: intervalHours = cnt;
         fotc_pkg::UNIT_DAY:  intervalHours = 11'(cnt * fotc_pkg::HOURS_PER_DAY);
         fotc_pkg::UNIT_WEEK: intervalHours = 11'(cnt * fotc_pkg::HOURS_PER_WEEK);
      endcase
   endfunction : intervalHours

   function automatic logic [15:0] mapCurrent(input logic [VALUE_W-1:0] v, input logic [VALUE_W-1:0] lo,
                                              input logic [VALUE_W-1:0] hi);
      logic [31:0] num;
      num = 32'(v - lo) * fotc_pkg::CUR_SPAN_UA;
      if (v <= lo) mapCurrent = fotc_pkg::CUR_MIN_UA;
      else if (v >= hi) mapCurrent = fotc_pkg::CUR_MAX_UA;
      else mapCurrent = fotc_pkg::CUR_MIN_UA + 16'(num / 32'(hi - lo));
   endfunction : mapCurrent

   fotc_sw_if #(.W(VALUE_W)) sw1If ();
   fotc_sw_if #(.W(VALUE_W)) sw2If ();

   logic [VALUE_W-1:0] upper1_q, lower1_q, upper2_q, lower2_q;
   logic [VALUE_W-1:0] anStart_q, anEnd_q, damped_q, damped_d;
   logic [VALUE_W-1:0] max_q, min_q;
   logic               memValid_q;
   logic [31:0]        total_q, total_d, saved_q, pulseAcc_q;
   logic               flash_q, latch_q, pinPrev_q, pinKnown_q, firePrev_q;
   logic [PRE_W-1:0]   hourPre_q;
   logic [10:0]        hoursDone_q;
   logic [PLS_W-1:0]   stretch_q;
   logic               out1_q, out2_q, oe2_q;
   logic [15:0]        current_q, diameter_q;
   logic [2:0]         refused_q;
   fotc_pkg::fotc_menu_type menu_q, menu_d;

   logic signed [VALUE_W:0] dampDiff;
   logic               spanOk, pointsOk, diamOk, force2;
   logic               rstMode, trigNow, resetFire, resetFirst;
   logic               countStop, countTick, clearAll, autoClear;
   logic [10:0]        targetHours;
   logic               timerOn, hourTick, pulseHit, pulseLevel;
   logic               out1Raw, out2Raw;
   logic [15:0]        current_d;

   // Thresholds act on the damped value, as the outputs do
   assign sw1If.value  = damped_q;
   assign sw1If.upper  = upper1_q;
   assign sw1If.lower  = lower1_q;
   assign sw1If.window = firstOutputFunction inside {fotc_pkg::FN_WIN_NO, fotc_pkg::FN_WIN_NC};
   assign sw1If.closed = firstOutputFunction inside {fotc_pkg::FN_HYST_NC, fotc_pkg::FN_WIN_NC};
   assign sw2If.value  = damped_q;
   assign sw2If.upper  = upper2_q;
   assign sw2If.lower  = lower2_q;
   assign sw2If.window = secondOutputFunction inside {fotc_pkg::FN_WIN_NO, fotc_pkg::FN_WIN_NC};
   assign sw2If.closed = secondOutputFunction inside {fotc_pkg::FN_HYST_NC, fotc_pkg::FN_WIN_NC};

   fotc_switch u_sw1 (.clock(clock), .rst_n(rst_n), .port(sw1If.sw));
   fotc_switch u_sw2 (.clock(clock), .rst_n(rst_n), .port(sw2If.sw));

   // Shift approximates 0.2 s steps; zero passes the sample through
   assign dampDiff = $signed({1'b0, flowValue}) - $signed({1'b0, damped_q});
   assign damped_d = VALUE_W'($signed({1'b0, damped_q}) + (dampDiff >>> ((dampingConstant > fotc_pkg::DAMP_MAX_SHIFT) ?
                     fotc_pkg::DAMP_MAX_SHIFT : dampingConstant)));

   assign spanOk   = (analogueEndValue > analogueStartValue) &&
                     (analogueEndValue - analogueStartValue >= SPAN_MIN);
   assign pointsOk = lowerReturnPoint < upperSwitchPoint;
   assign diamOk   = (menu_q == fotc_pkg::MENU_EXT) && !factoryLock;

   // Edges need one known sample, so a pin high out of reset is no edge
   assign rstMode  = secondOutputFunction == fotc_pkg::FN_RSTIN;
   assign trigNow  = (resetTrigger == fotc_pkg::TRIG_RISE) ? (pinKnown_q && out2In && !pinPrev_q) :
                     (resetTrigger == fotc_pkg::TRIG_FALL) ? (pinKnown_q && !out2In && pinPrev_q) :
                     (resetTrigger == fotc_pkg::TRIG_HIGH) ? out2In : !out2In;
   assign resetFire  = rstMode && trigNow;
   assign resetFirst = resetFire && !firePrev_q;

   assign targetHours = intervalHours(intervalUnit, intervalCount);
   assign timerOn     = targetHours != 11'h000;
   assign hourTick    = hourPre_q == HOUR_LAST;
   assign autoClear   = timerOn && hourTick && (hoursDone_q + 11'h001 == targetHours);
   assign clearAll    = manualCounterClear || autoClear || resetFire;

   assign countStop = internalError && (errorBehaviour1 != fotc_pkg::ERR_NORMAL ||
                      errorBehaviour2 != fotc_pkg::ERR_NORMAL);
   assign countTick = quantityTick && !countStop;
   // Plain increment wraps to zero at the 32-bit limit
   assign total_d   = clearAll ? 32'h0000_0000 : (countTick ? total_q + 32'h0000_0001 : total_q);

   assign pulseHit   = pulseRepeatEnable && countTick && !clearAll &&
                       (pulseAcc_q + 32'h0000_0001 >= pulseQuantityValue);
   assign pulseLevel = pulseRepeatEnable ? (stretch_q != '0) : latch_q;

   assign out1Raw = isSwitch(firstOutputFunction) ? sw1If.level :
                    (firstOutputFunction == fotc_pkg::FN_PULSE) ? pulseLevel : 1'b0;
   assign out2Raw = isSwitch(secondOutputFunction) ? sw2If.level : 1'b0;
   assign force2  = internalError && errorBehaviour2 != fotc_pkg::ERR_NORMAL;
   assign current_d = (secondOutputFunction != fotc_pkg::FN_ANALOG) ? fotc_pkg::CUR_NONE_UA :
                      !force2 ? mapCurrent(damped_q, anStart_q, anEnd_q) :
                      (errorBehaviour2 == fotc_pkg::ERR_ON) ? fotc_pkg::CUR_MAX_UA : fotc_pkg::CUR_MIN_UA;

   always_comb begin
      menu_d = menu_q;
      unique case (menu_q)
         fotc_pkg::MENU_MAIN: if (extendedMenu) menu_d = fotc_pkg::MENU_EXT;
         fotc_pkg::MENU_EXT:  if (menuExit) menu_d = fotc_pkg::MENU_MAIN;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         upper1_q <= VALUE_W'(RANGE_FINAL);
         lower1_q <= '0;
         upper2_q <= VALUE_W'(RANGE_FINAL);
         lower2_q <= '0;
      end else begin
         if (switchWrite1 && pointsOk) {upper1_q, lower1_q} <= {upperSwitchPoint, lowerReturnPoint};
         if (switchWrite2 && pointsOk) {upper2_q, lower2_q} <= {upperSwitchPoint, lowerReturnPoint};
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         anStart_q  <= '0;
         anEnd_q    <= VALUE_W'(RANGE_FINAL);
         diameter_q <= DIAMETER_RST;
         menu_q     <= fotc_pkg::MENU_MAIN;
         refused_q  <= 3'h0;
      end else begin
         if (analogueWrite && spanOk) {anStart_q, anEnd_q} <= {analogueStartValue, analogueEndValue};
         if (diameterWrite && diamOk) diameter_q <= diameterValue;
         menu_q    <= menu_d;
         refused_q <= {diameterWrite && !diamOk, analogueWrite && !spanOk, (switchWrite1 || switchWrite2) && !pointsOk};
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         damped_q   <= '0;
         max_q      <= '0;
         min_q      <= '0;
         memValid_q <= 1'b0;
      end else if (flowValid) begin
         damped_q   <= damped_d;
         max_q      <= (!memValid_q || minMaxClear || flowValue > max_q) ? flowValue : max_q;
         min_q      <= (!memValid_q || minMaxClear || flowValue < min_q) ? flowValue : min_q;
         memValid_q <= 1'b1;
      end else if (minMaxClear) begin
         memValid_q <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         total_q     <= 32'h0000_0000;
         hourPre_q   <= '0;
         hoursDone_q <= 11'h000;
      end else begin
         total_q     <= total_d;
         hourPre_q   <= (clearAll || !timerOn || hourTick) ? '0 : hourPre_q + PRE_W'(1'b1);
         hoursDone_q <= (clearAll || !timerOn) ? 11'h000 : (hourTick ? hoursDone_q + 11'h001 : hoursDone_q);
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         saved_q    <= 32'h0000_0000;
         flash_q    <= 1'b0;
         pinPrev_q  <= 1'b0;
         pinKnown_q <= 1'b0;
         firePrev_q <= 1'b0;
      end else begin
         if (resetFirst) saved_q <= total_q;
         flash_q    <= resetFirst || (flash_q && !flashAck);
         pinPrev_q  <= out2In;
         pinKnown_q <= 1'b1;
         firePrev_q <= resetFire;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pulseAcc_q <= 32'h0000_0000;
         stretch_q  <= '0;
         latch_q    <= 1'b0;
      end else begin
         pulseAcc_q <= (clearAll || pulseHit) ? 32'h0000_0000 : (countTick ? pulseAcc_q + 32'h0000_0001 : pulseAcc_q);
         stretch_q  <= pulseHit ? PLS_W'(PULSE_CYCLES) : ((stretch_q != '0) ? stretch_q - PLS_W'(1'b1) : stretch_q);
         latch_q    <= !clearAll && (latch_q || (pulseQuantityValue != 32'h0000_0000 &&
                       total_q >= pulseQuantityValue));
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         out1_q    <= 1'b0;
         out2_q    <= 1'b0;
         oe2_q     <= 1'b0;
         current_q <= fotc_pkg::CUR_NONE_UA;
      end else begin
         out1_q    <= applyErr(out1Raw, errorBehaviour1, internalError);
         out2_q    <= isSwitch(secondOutputFunction) && applyErr(out2Raw, errorBehaviour2, internalError);
         oe2_q     <= isSwitch(secondOutputFunction);
         current_q <= current_d;
      end
   end

   assign out1Level         = out1_q;
   assign out2Out           = out2_q;
   assign out2Oe            = oe2_q;
   assign analogueCurrent   = current_q;
   assign totaliser         = total_q;
   assign savedTotal        = saved_q;
   assign savedFlash        = flash_q;
   assign maxFlowMemory     = max_q;
   assign minFlowMemory     = min_q;
   assign flowMemoryValid   = memValid_q;
   assign dampedFlow        = damped_q;
   assign inSubmenu         = menu_q == fotc_pkg::MENU_EXT;
   assign pipeInnerDiameter = diameter_q;
   assign switchRefused     = refused_q[0];
   assign analogueRefused   = refused_q[1];
   assign diameterRefused   = refused_q[2];

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_manual_clear: assert property (manualCounterClear |=> total_q == 32'h0000_0000)
      else $error("manual clear did not zero counter");
   a_manual_timed: assert property (manualCounterClear && timerOn |=> hoursDone_q == 11'h000 && hourPre_q == '0)
      else $error("manual clear did not restart interval");
   a_trigger_save: assert property (resetFirst |=> total_q == 32'h0000_0000 && flash_q && saved_q == $past(total_q))
      else $error("reset input did not save and clear");
   a_trigger_mode: assert property (!rstMode && !manualCounterClear && !autoClear && !countTick |=> $stable(total_q))
      else $error("reset input fired outside input mode");
   a_error_stop: assert property (countStop && !clearAll |=> $stable(total_q))
      else $error("counter ran during internal error");
   a_force_on: assert property (internalError && errorBehaviour1 == fotc_pkg::ERR_ON |=> out1_q)
      else $error("output one not forced on");
   a_normal_follow: assert property (errorBehaviour1 == fotc_pkg::ERR_NORMAL &&
      isSwitch(firstOutputFunction) |=> out1_q == $past(sw1If.level))
      else $error("output one ignored its switching level");
   a_analog_floor: assert property (secondOutputFunction == fotc_pkg::FN_ANALOG && !force2 &&
      damped_q <= anStart_q |=> current_q == fotc_pkg::CUR_MIN_UA)
      else $error("start value not at 4 mA");
   a_analog_top: assert property (secondOutputFunction == fotc_pkg::FN_ANALOG && !force2 &&
      damped_q >= anEnd_q && anEnd_q > anStart_q |=> current_q == fotc_pkg::CUR_MAX_UA)
      else $error("end value not at 20 mA");
   a_span_refuse: assert property (analogueWrite && !spanOk |=> $stable(anStart_q) && $stable(anEnd_q) && refused_q[1])
      else $error("narrow analogue span accepted");
   a_minmax_order: assert property (memValid_q |-> min_q <= max_q)
      else $error("min above max");
   a_diam_lock: assert property (diameterWrite && !diamOk |=> $stable(diameter_q))
      else $error("diameter changed outside submenu");

   c_auto_clear: cover property (autoClear);
   c_reset_input: cover property (resetFirst ##1 flash_q);
   c_pulse_hit: cover property (pulseHit ##1 out1_q == 1'b0 ##1 out1_q);
   c_manual_timed: cover property (manualCounterClear && timerOn);
endmodule : fotc_top
`default_nettype wire

/* dv/fotc_ctrl_model.sv */
/*
 Far side: controller and external reset source on pin two.
 Assumes the pin resolves from the design's enable.
*/
`timescale 1ns/1ps
`default_nettype none
module fotc_ctrl_model (
   // Pin and source
   input  wire logic out2Out,
   input  wire logic out2Oe,
   input  wire logic srcLevel,
   output logic      out2In
);
   // Source only wins while the design releases the pin
   assign out2In = out2Oe ? out2Out : srcLevel;
endmodule : fotc_ctrl_model
`default_nettype wire

/* dv/tb_flow_output_totaliser_config.sv */
/*
 Bench of the output and totaliser block.
 Assumes short hour count.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; $display("unexpected %0t %h %h", $time, a, b); end end
`define PLS(s, d) @(posedge clock) begin d; s <= 1; end @(posedge clock) s <= 0; #1
module tb_flow_output_totaliser_config;
   logic clock = 0, rst_n = 0, flowValid = 0, quantityTick = 0, internalError = 0, srcLevel = 0, factoryLock = 0;
   logic switchWrite1 = 0, switchWrite2 = 0, analogueWrite = 0, pulseRepeatEnable = 0, menuExit = 0, flashAck = 0;
   logic manualCounterClear = 0, minMaxClear = 0, extendedMenu = 0, diameterWrite = 0, out1Level, out2Out, out2Oe;
   logic out2In, savedFlash, flowMemoryValid, inSubmenu, switchRefused, analogueRefused, diameterRefused;
   logic [15:0] flowValue = 0, upperSwitchPoint = 0, lowerReturnPoint = 0, analogueStartValue = 0, diameterValue = 0;
   logic [15:0] analogueEndValue = 0, analogueCurrent, maxFlowMemory, minFlowMemory, dampedFlow, pipeInnerDiameter;
   logic [31:0] pulseQuantityValue = 0, totaliser, savedTotal;
   logic [4:0]  intervalCount = 1;
   logic [2:0]  dampingConstant = 0;
   fotc_pkg::fotc_func_type firstOutputFunction = fotc_pkg::FN_HYST_NO, secondOutputFunction = fotc_pkg::FN_RSTIN;
   fotc_pkg::fotc_err_type  errorBehaviour1 = fotc_pkg::ERR_NORMAL, errorBehaviour2 = fotc_pkg::ERR_NORMAL;
   fotc_pkg::fotc_trig_type resetTrigger = fotc_pkg::TRIG_RISE;
   fotc_pkg::fotc_unit_type intervalUnit = fotc_pkg::UNIT_HOUR;
   int err_count = 0, comparisons = 0;
   // Refused flag, start, end
   logic [32:0] rows [3] = '{{1'b0, 16'h0000, 16'h3FFF}, {1'b1, 16'h0000, 16'h3FFE}, {1'b1, 16'h0010, 16'h0005}};
   always #2.5 clock = ~clock;
   fotc_top #(.HOUR_CYCLES(20), .PULSE_CYCLES(4)) dut_u (.*);
   fotc_ctrl_model ctrl_u (.out2Out(out2Out), .out2Oe(out2Oe), .srcLevel(srcLevel), .out2In(out2In));
   task automatic w(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : w
   task complete_run;
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : complete_run
   initial begin
      #50000;
      err_count++;
      complete_run();
   end
   initial begin
      w(16);
      @(posedge clock) rst_n <= 1;
      w(2);
      `CHK(pipeInnerDiameter, 16'h0032)
      foreach (rows[i]) begin
         `PLS(analogueWrite, {analogueStartValue, analogueEndValue} <= rows[i][31:0]);
         `CHK(analogueRefused, rows[i][32])
      end
      `PLS(switchWrite2, {upperSwitchPoint, lowerReturnPoint} <= {16'h0080, 16'h0100});
      `CHK(switchRefused, 1'h1)
      @(posedge clock) secondOutputFunction <= fotc_pkg::FN_ANALOG;
      `PLS(flowValid, flowValue <= 16'h3FFF);
      w(3);
      `CHK(analogueCurrent, fotc_pkg::CUR_MAX_UA)
      `PLS(flowValid, flowValue <= 16'h0000);
      w(3);
      `CHK(analogueCurrent, fotc_pkg::CUR_MIN_UA)
      `CHK({maxFlowMemory, minFlowMemory}, {16'h3FFF, 16'h0000})
      @(posedge clock) secondOutputFunction <= fotc_pkg::FN_RSTIN;
      `PLS(switchWrite1, {upperSwitchPoint, lowerReturnPoint} <= {16'h0100, 16'h0080});
      `PLS(manualCounterClear, );
      repeat (3) begin `PLS(quantityTick, ); end
      `CHK(totaliser, 32'h0000_0003)
      w(8);
      `CHK(totaliser, 32'h0000_0003)
      w(8);
      `CHK(totaliser, 32'h0000_0000)
      @(posedge clock) intervalUnit <= fotc_pkg::UNIT_OFF;
      `PLS(flowValid, flowValue <= 16'h0200);
      w(4);
      `CHK(out1Level, 1'b1)
      @(posedge clock) begin internalError <= 1; errorBehaviour1 <= fotc_pkg::ERR_OFF; end
      `PLS(quantityTick, );
      w(2);
      `CHK({out1Level, totaliser}, {1'b0, 32'h0000_0000})
      @(posedge clock) errorBehaviour1 <= fotc_pkg::ERR_NORMAL;
      `PLS(quantityTick, );
      w(2);
      `CHK({out1Level, totaliser}, {1'b1, 32'h0000_0001})
      `PLS(flowValid, flowValue <= 16'h0000);
      @(posedge clock) errorBehaviour1 <= fotc_pkg::ERR_ON;
      w(4);
      `CHK(out1Level, 1'b1)
      @(posedge clock) begin internalError <= 0; srcLevel <= 1; end
      w(3);
      `CHK({totaliser, savedTotal, savedFlash}, {32'h0000_0000, 32'h0000_0001, 1'b1})
      `PLS(flashAck, );
      `CHK(savedFlash, 1'h0)
      `PLS(minMaxClear, );
      `CHK(flowMemoryValid, 1'h0)
      @(posedge clock) dampingConstant <= 3'h1;
      `PLS(flowValid, flowValue <= 16'h0100);
      `CHK({flowMemoryValid, maxFlowMemory, minFlowMemory}, {1'h1, 16'h0100, 16'h0100})
      `CHK(dampedFlow, 16'h0080)
      @(posedge clock) secondOutputFunction <= fotc_pkg::FN_WIN_NO;
      @(posedge clock) begin firstOutputFunction <= fotc_pkg::FN_PULSE; pulseQuantityValue <= 32'h0000_0002; end
      `PLS(quantityTick, );
      `CHK(out1Level, 1'h0)
      `PLS(quantityTick, );
      w(2);
      `CHK(out1Level, 1'h1)
      `CHK({out2Oe, out2Out}, 2'h3)
      @(posedge clock) secondOutputFunction <= fotc_pkg::FN_WIN_NC;
      w(2);
      `CHK({out2Oe, out2Out}, 2'h2)
      `PLS(diameterWrite, diameterValue <= 16'h0040);
      `CHK(diameterRefused, 1'b1)
      `PLS(extendedMenu, );
      `CHK(inSubmenu, 1'b1)
      `PLS(diameterWrite, );
      w(1);
      `CHK(pipeInnerDiameter, 16'h0040)
      @(posedge clock) factoryLock <= 1;
      `PLS(diameterWrite, diameterValue <= 16'h0050);
      `CHK({diameterRefused, pipeInnerDiameter}, {1'h1, 16'h0040})
      `PLS(menuExit, );
      `CHK(inSubmenu, 1'h0)
      @(posedge clock) rst_n <= 0;
      w(2);
      @(posedge clock) rst_n <= 1;
      w(1);
      `CHK({pipeInnerDiameter, totaliser}, {16'h0032, 32'h0000_0000})
      complete_run();
   end
endmodule : tb_flow_output_totaliser_config
`default_nettype wire
